/* File: rtl/usw_pkg.sv */
// Shared constants for the suspend and wake event logic.
// Assumes a 250 MHz core clock; all timing is counted in core clock cycles.
package usw_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Times in microseconds (revert time in nanoseconds), derived cycle counts below
  localparam int unsigned IDLE_DETECT_US = 3000;
  localparam int unsigned SUSPEND_LIMIT_US = 10000;
  localparam int unsigned RESUME_IDLE_US = 5000;
  localparam int unsigned REVERT_NS = 125000;
  localparam int unsigned RESUME_WAIT_US = 10000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned IDLE_DETECT_CYC = IDLE_DETECT_US * CLK_MHZ;
  localparam int unsigned SUSPEND_LIMIT_CYC = SUSPEND_LIMIT_US * CLK_MHZ;
  localparam int unsigned RESUME_IDLE_CYC = RESUME_IDLE_US * CLK_MHZ;
  localparam int unsigned REVERT_CYC = REVERT_NS / CLK_PERIOD_NS;
  localparam int unsigned RESUME_WAIT_CYC = RESUME_WAIT_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // Register byte offsets (designer's own map)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_CPUCFG = 8'h0c;
  localparam logic [7:0] OFS_WAKE = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  // Status and mask bit positions
  localparam int unsigned BIT_WAKE_FLAG = 2;
  localparam int unsigned BIT_SUSP_FLAG = 4;
  // Control bit positions
  localparam int unsigned BIT_RWU_EN = 5;
  localparam int unsigned BIT_LP_EN = 6;
  // Port pin detect enables sit at cpu_config_reg bits 2..5
  localparam int unsigned BIT_PIN_EN_LO = 2;
  localparam int unsigned NUM_PINS = 4;
  // Wake event register: bit 0 bus power, bits 1..4 pins a..d
  localparam int unsigned NUM_SRC = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [4:0] {
    USW_ACTIVE = 5'b00001,
    USW_REVERT = 5'b00010,
    USW_REQUEST = 5'b00100,
    USW_SUSPEND = 5'b01000,
    USW_RESUME = 5'b10000
  } usw_state_e;
endpackage

/* File: rtl/usw_if.sv */
// AXI4-Lite link between the firmware-side master and the event block.
// Assumes one clock and active-low reset shared by both ends.
`timescale 1ns/1ps
interface usw_if (
  input wire logic clock,
  input wire logic rstn
);
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic irq;
  modport dev (
    input clock, rstn, awaddr, awvalid, wdata, wstrb, wvalid, bready,
    input araddr, arvalid, rready,
    output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
    output irq
  );
  modport fw (
    input clock, rstn, awready, wready, bresp, bvalid, arready, rdata,
    input rresp, rvalid, irq,
    output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid,
    output rready
  );
endinterface

/* File: rtl/usw_dev.sv */
// Suspend entry and wake event logic with an AXI4-Lite register slave.
// Assumes bus idle and speed indications from a PHY, pins synchronous.
`timescale 1ns/1ps
// Contract
// RULE_01: Start suspend path after 3 ms idle
// RULE_02: Be suspended within 10 ms of idle; no limit timer here, suspend waits for the flag clear
// RULE_03: Resume only after 5 ms continuous idle
// RULE_04: Full speed: set suspend flag and interrupt
// RULE_05: High speed: revert within 0.125 ms first
// RULE_06: Firmware clears suspend flag before 10 ms
// RULE_07: Suspend on flag clear, stop clock if enabled
// RULE_08: Pulse per pin change, ORed together
// RULE_09: Set wake flag if enabled and clear
// RULE_10: Wake interrupt needs clock, enable, clear flag
// RULE_11: Pending wake flag blocks further interrupts
// RULE_12: Write 1 clears wake flag, sources kept
// RULE_13: Firmware clears wake flag before source bits
// RULE_14: Firmware reads sources, handles each
// RULE_15: Write 1 clears only selected source bits
// RULE_16: Suspend flag bit 4, write 1 clears
// RULE_17: Resume on wake clear or 10 ms
// RULE_18: Bus power always, pins gated by enables
// RULE_19: Stopped clock latches event, interrupts later
// RULE_20: Idle counter restarts on bus activity
// RULE_21: Interrupt is OR of masked flags
module usw_dev
  import usw_pkg::*;
#(
  parameter int unsigned IDLE_CYC = IDLE_DETECT_CYC,
  parameter int unsigned REV_CYC = REVERT_CYC,
  parameter int unsigned RES_IDLE_CYC = RESUME_IDLE_CYC,
  parameter int unsigned RES_WAIT_CYC = RESUME_WAIT_CYC
) (
  usw_if.dev bus,
  input wire logic bus_idle,
  input wire logic high_speed,
  input wire logic bus_power,
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic wake_pin_c,
  input wire logic wake_pin_d,
  output logic revert_full_speed,
  output logic suspended,
  output logic core_clock_stop,
  output logic resume_signal
);
  logic clock;
  logic rstn;
  assign clock = bus.clock;
  assign rstn = bus.rstn;

  usw_state_e state;
  usw_state_e next_state;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] tmr;
  logic suspend_request_flag;
  logic wake_event_flag;
  logic [7:0] usb_irq_mask_reg;
  logic [7:0] usb_ctrl_reg;
  logic [7:0] cpu_config_reg;
  logic [NUM_SRC-1:0] wake_event_reg;
  logic [NUM_SRC-1:0] pin_q;
  logic [NUM_SRC-1:0] pin_now;
  logic [NUM_SRC-1:0] pin_en;
  logic [NUM_SRC-1:0] change_pulse;
  logic set_pulse;
  logic wake_pend;
  logic [1:0] aw_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pin sampling and change detection
  assign pin_now = {wake_pin_d, wake_pin_c, wake_pin_b, wake_pin_a, bus_power};
  assign pin_en = {cpu_config_reg[BIT_PIN_EN_LO +: NUM_PINS], 1'b1}; // RULE_18
  assign change_pulse = (pin_now ^ pin_q) & pin_en; // RULE_08
  assign set_pulse = |change_pulse; // RULE_08
  assign core_clock_stop = (state == USW_SUSPEND) &
    usb_ctrl_reg[BIT_LP_EN]; // RULE_07
  assign suspended = (state == USW_SUSPEND);
  assign revert_full_speed = (state == USW_REVERT);
  assign resume_signal = (state == USW_RESUME);
  wire idle_done = (idle_cnt >= CNT_W'(IDLE_CYC)); // RULE_01
  wire rwu_ok = (idle_cnt >= CNT_W'(RES_IDLE_CYC)); // RULE_03
  // Leave on the last revert cycle so the state lasts REV_CYC cycles at most
  wire rev_done = (tmr >= CNT_W'(REV_CYC - 1)); // RULE_05
  wire res_timeout = (tmr >= CNT_W'(RES_WAIT_CYC)); // RULE_17

  // Bus write decode
  wire wr_go = (aw_have == 2'b11) & ~bus.bvalid;
  wire wr_status = wr_go & (aw_addr == OFS_STATUS) & w_strb[0];
  wire wr_mask = wr_go & (aw_addr == OFS_MASK) & w_strb[0];
  wire wr_ctrl = wr_go & (aw_addr == OFS_CTRL) & w_strb[0];
  wire wr_cfg = wr_go & (aw_addr == OFS_CPUCFG) & w_strb[0];
  wire wr_wake = wr_go & (aw_addr == OFS_WAKE) & w_strb[0];
  wire clr_susp = wr_status & w_data[BIT_SUSP_FLAG]; // RULE_16
  wire clr_wake = wr_status & w_data[BIT_WAKE_FLAG]; // RULE_12
  wire wr_mapped = (aw_addr == OFS_STATUS) | (aw_addr == OFS_MASK) |
    (aw_addr == OFS_CTRL) | (aw_addr == OFS_CPUCFG) |
    (aw_addr == OFS_WAKE) | (aw_addr == OFS_STATE);
  wire wake_en = usb_irq_mask_reg[BIT_WAKE_FLAG];
  // Clock stopped: event is only latched, flag waits for clock return
  wire clk_run = ~core_clock_stop; // RULE_19
  wire set_wake = (set_pulse | wake_pend) & clk_run & wake_en &
    ~wake_event_flag; // RULE_09 RULE_10 RULE_11

  // Suspend state machine
  always_comb begin
    next_state = state;
    case (state)
      USW_ACTIVE: begin
        if (idle_done) begin
          next_state = high_speed ? USW_REVERT : USW_REQUEST; // RULE_04
        end
      end
      USW_REVERT: begin
        if (rev_done) begin
          next_state = USW_REQUEST; // RULE_05
        end
      end
      USW_REQUEST: begin
        if (!bus_idle) begin
          next_state = USW_ACTIVE;
        end else if (!suspend_request_flag) begin
          next_state = USW_SUSPEND; // RULE_07 RULE_02
        end
      end
      USW_SUSPEND: begin
        if (!bus_idle) begin
          next_state = USW_ACTIVE;
        end else if (usb_ctrl_reg[BIT_RWU_EN] && wake_event_flag &&
                     rwu_ok && (clr_wake || res_timeout)) begin
          next_state = USW_RESUME; // RULE_17 RULE_03
        end
      end
      USW_RESUME: begin
        next_state = USW_ACTIVE;
      end
      default: next_state = USW_ACTIVE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= USW_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Idle counter restarted by bus activity
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idle_cnt <= '0;
    end else if (!bus_idle) begin
      idle_cnt <= '0; // RULE_20
    end else if (idle_cnt != '1) begin
      idle_cnt <= idle_cnt + 1'b1; // RULE_20
    end
  end

  // Revert timer and resume wait timer, restarted on state change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tmr <= '0;
    end else if (next_state != state) begin
      tmr <= '0;
    end else if (tmr != '1 && (state != USW_SUSPEND || wake_event_flag)) begin
      tmr <= tmr + 1'b1;
    end
  end

  // Suspend request flag: set beats clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      suspend_request_flag <= 1'b0;
    end else if (next_state == USW_REQUEST && state != USW_REQUEST) begin
      suspend_request_flag <= 1'b1; // RULE_04 RULE_05
    end else if (clr_susp) begin
      suspend_request_flag <= 1'b0; // RULE_16
    end
  end

  // Wake flag, pending latch, source bits and pin history
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_event_flag <= 1'b0;
      wake_pend <= 1'b0;
      wake_event_reg <= '0;
      pin_q <= '0;
    end else begin
      pin_q <= pin_now;
      if (set_wake) begin
        wake_event_flag <= 1'b1; // RULE_09
      end else if (clr_wake) begin
        wake_event_flag <= 1'b0; // RULE_12
      end
      if (set_wake) begin
        wake_pend <= 1'b0;
      end else if (set_pulse & wake_en & ~clk_run) begin
        wake_pend <= 1'b1; // RULE_19
      end
      // New events win over a same-cycle clear of their bit
      wake_event_reg <= (wake_event_reg &
        ~(wr_wake ? w_data[NUM_SRC-1:0] : '0)) | change_pulse; // RULE_15
    end
  end

  // Control and configuration registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      usb_irq_mask_reg <= '0;
      usb_ctrl_reg <= '0;
      cpu_config_reg <= '0;
    end else begin
      if (wr_mask) usb_irq_mask_reg <= w_data[7:0];
      if (wr_ctrl) usb_ctrl_reg <= w_data[7:0];
      if (wr_cfg) cpu_config_reg <= w_data[7:0];
    end
  end

  // Interrupt line: masked flags ORed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus.irq <= 1'b0;
    end else begin
      bus.irq <= (wake_event_flag & wake_en) | (suspend_request_flag &
        usb_irq_mask_reg[BIT_SUSP_FLAG]); // RULE_21
    end
  end

  // Write channel capture, response after both halves taken
  assign bus.awready = ~aw_have[0] & ~bus.bvalid;
  assign bus.wready = ~aw_have[1] & ~bus.bvalid;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_have <= 2'b00;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bus.bvalid <= 1'b0;
      bus.bresp <= RESP_OKAY;
    end else begin
      if (bus.awvalid & bus.awready) begin
        aw_have[0] <= 1'b1;
        aw_addr <= bus.awaddr;
      end
      if (bus.wvalid & bus.wready) begin
        aw_have[1] <= 1'b1;
        w_data <= bus.wdata;
        w_strb <= bus.wstrb;
      end
      if (wr_go) begin
        bus.bvalid <= 1'b1;
        bus.bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        aw_have <= 2'b00;
      end else if (bus.bvalid & bus.bready) begin
        bus.bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one registered answer per address
  assign bus.arready = ~bus.rvalid;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = '0;
    case (bus.araddr)
      OFS_STATUS: begin
        rd_val[BIT_WAKE_FLAG] = wake_event_flag;
        rd_val[BIT_SUSP_FLAG] = suspend_request_flag;
      end
      OFS_MASK: rd_val[7:0] = usb_irq_mask_reg;
      OFS_CTRL: rd_val[7:0] = usb_ctrl_reg;
      OFS_CPUCFG: rd_val[7:0] = cpu_config_reg;
      OFS_WAKE: rd_val[NUM_SRC-1:0] = wake_event_reg;
      OFS_STATE: rd_val[4:0] = state;
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus.rvalid <= 1'b0;
      bus.rdata <= '0;
      bus.rresp <= RESP_OKAY;
    end else if (bus.arvalid & bus.arready) begin
      bus.rvalid <= 1'b1;
      bus.rdata <= rd_val;
      bus.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bus.rready) begin
      bus.rvalid <= 1'b0;
    end
  end
endmodule // usw_dev

/* File: rtl/usw_fw.sv */
// Firmware-side AXI4-Lite master: one command in, one access out.
// Assumes user holds cmd_valid until cmd_ready; one access at a time.
`timescale 1ns/1ps
module usw_fw
  import usw_pkg::*;
(
  usw_if.fw bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic [1:0] rsp_resp,
  output logic irq_seen
);
  logic busy;
  logic clock;
  logic rstn;
  assign clock = bus.clock;
  assign rstn = bus.rstn;
  // Firmware duties (RULE_06, RULE_13, RULE_14, RULE_15) are sequenced by
  // the user through this port in the required order.
  assign cmd_ready = ~busy;
  assign irq_seen = bus.irq;
  wire take = cmd_valid & ~busy;

  // Issue and release channels, collect the answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      bus.awvalid <= 1'b0;
      bus.wvalid <= 1'b0;
      bus.arvalid <= 1'b0;
      bus.bready <= 1'b0;
      bus.rready <= 1'b0;
      bus.awaddr <= '0;
      bus.araddr <= '0;
      bus.wdata <= '0;
      bus.wstrb <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_resp <= RESP_OKAY;
    end else begin
      rsp_valid <= 1'b0;
      if (take) begin
        busy <= 1'b1;
        if (cmd_write) begin
          bus.awvalid <= 1'b1;
          bus.wvalid <= 1'b1;
          bus.awaddr <= cmd_addr;
          bus.wdata <= cmd_wdata;
          bus.wstrb <= 4'hf;
          bus.bready <= 1'b1;
        end else begin
          bus.arvalid <= 1'b1;
          bus.araddr <= cmd_addr;
          bus.rready <= 1'b1;
        end
      end
      if (bus.awvalid & bus.awready) bus.awvalid <= 1'b0;
      if (bus.wvalid & bus.wready) bus.wvalid <= 1'b0;
      if (bus.arvalid & bus.arready) bus.arvalid <= 1'b0;
      if (bus.bvalid & bus.bready) begin
        bus.bready <= 1'b0;
        busy <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_resp <= bus.bresp;
        rsp_rdata <= '0;
      end
      if (bus.rvalid & bus.rready) begin
        bus.rready <= 1'b0;
        busy <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_resp <= bus.rresp;
        rsp_rdata <= bus.rdata;
      end
    end
  end
endmodule // usw_fw

/* File: sim/usw_assertions.sv */
// Checker on the register link between the firmware master and the block.
// Assumes it is instantiated beside the interface and fed its signals.
`timescale 1ns/1ps
module usw_assertions
  import usw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Handshake steps
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  // Both halves are stored on the taking edge, the answer is raised one later
  a_write_answer: assert property (s_both_taken |-> ##2 bvalid)
    else $error("write answer late");
  a_write_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer not released");
  a_read_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer not released");
  a_read_answer: assert property (s_ar_taken |=> rvalid)
    else $error("read answer late");
  a_unmapped_read: assert property (s_ar_taken ##0 (araddr > OFS_STATE)
    |=> rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_bresp_holds: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  a_rdata_holds: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_arready_free: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  a_aw_holds: assert property (awvalid && !awready
    |=> awvalid && $stable(awaddr)) else $error("write address dropped");
  a_w_holds: assert property (wvalid && !wready
    |=> wvalid && $stable(wdata)) else $error("write data dropped");
  a_ar_holds: assert property (arvalid && !arready
    |=> arvalid && $stable(araddr)) else $error("read address dropped");
endmodule // usw_assertions

/* File: sim/usw_dev_test.sv */
// Bench joining both ends; commands drive registers, pins drive events.
// Assumes short timing parameters so suspend is reached in tens of cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module usw_dev_test
  import usw_pkg::*;
;
  localparam int IDLE = 20;
  localparam int REV = 4;
  logic clock, rstn, cmd_valid, cmd_write, cmd_ready, rsp_valid, irq_seen;
  logic bus_idle, high_speed, bus_power, revert_full_speed, suspended;
  logic core_clock_stop, resume_signal;
  logic [3:0] pins;
  logic [7:0] cmd_addr;
  logic [31:0] cmd_wdata, rsp_rdata, rd;
  logic [1:0] rsp_resp;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  int fails = 0, checked = 0, n;
  usw_if bus (.clock(clock), .rstn(rstn));
  usw_dev #(.IDLE_CYC(IDLE), .REV_CYC(REV), .RES_IDLE_CYC(30),
    .RES_WAIT_CYC(10)) usw_dev_i (.bus(bus), .bus_idle(bus_idle),
    .high_speed(high_speed), .bus_power(bus_power), .wake_pin_a(pins[0]),
    .wake_pin_b(pins[1]), .wake_pin_c(pins[2]), .wake_pin_d(pins[3]),
    .revert_full_speed(revert_full_speed), .suspended(suspended),
    .core_clock_stop(core_clock_stop), .resume_signal(resume_signal));
  usw_fw usw_fw_i (.bus(bus), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_resp(rsp_resp),
    .irq_seen(irq_seen));
  usw_assertions usw_assertions_i (.clock(bus.clock), .rstn(bus.rstn),
    .awaddr(bus.awaddr), .awvalid(bus.awvalid), .awready(bus.awready),
    .wdata(bus.wdata), .wvalid(bus.wvalid), .wready(bus.wready),
    .bresp(bus.bresp), .bvalid(bus.bvalid), .bready(bus.bready),
    .araddr(bus.araddr), .arvalid(bus.arvalid), .arready(bus.arready),
    .rdata(bus.rdata), .rresp(bus.rresp), .rvalid(bus.rvalid),
    .rready(bus.rready));
  // Clock at 4 ns
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // Verdict and end of run
  task results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One command held until taken, then wait for its answer
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    // Wait for the answer; only the watchdog ends a hang
    do @(posedge clock); while (rsp_valid !== 1'b1);
    rd = rsp_rdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task hop(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Flip one event source: 0 bus power, 1..4 pins a..d
  task flip(input int s);
    @(posedge clock);
    if (s == 0) bus_power <= ~bus_power;
    else pins[s-1] <= ~pins[s-1];
    hop(3);
  endtask
  // Watchdog
  initial begin
    hop(20000);
    fails++;
    results();
  end
  initial begin
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
    {bus_idle, high_speed, bus_power, pins} = '0;
    rstn = 0;
    hop(16);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(ofs[i], (i == 5) ? 32'h1 : 32'h0);
    acc(1'b1, OFS_STATE, 32'h1f);
    rdchk(OFS_STATE, 32'h1);
    acc(1'b0, 8'h18, 32'h0);
    `CHK(rsp_resp, RESP_SLVERR)
    acc(1'b1, 8'h18, 32'h1);
    `CHK(rsp_resp, RESP_SLVERR)
    // Each source sets its bit; one shared flag cleared alone
    acc(1'b1, OFS_MASK, 32'h14);
    acc(1'b1, OFS_CPUCFG, 32'h3c);
    for (int i = 0; i < 5; i++) begin
      flip(i);
      `CHK(irq_seen, 1'b1)
      rdchk(OFS_WAKE, 32'h1 << i);
      rdchk(OFS_STATUS, 32'h4);
      acc(1'b1, OFS_STATUS, 32'h4);
      hop(2);
      `CHK(irq_seen, 1'b0)
      rdchk(OFS_WAKE, 32'h1 << i);
      acc(1'b1, OFS_WAKE, 32'h1 << i);
      rdchk(OFS_WAKE, 32'h0);
    end
    flip(0);
    flip(1);
    rdchk(OFS_WAKE, 32'h3);
    acc(1'b1, OFS_STATUS, 32'h4);
    rdchk(OFS_STATUS, 32'h0);
    acc(1'b1, OFS_WAKE, 32'h1);
    rdchk(OFS_WAKE, 32'h2);
    acc(1'b1, OFS_WAKE, 32'h2);
    acc(1'b1, OFS_CPUCFG, 32'h0);
    for (int i = 1; i < 5; i++) flip(i);
    rdchk(OFS_WAKE, 32'h0);
    acc(1'b1, OFS_MASK, 32'h10);
    flip(0);
    rdchk(OFS_WAKE, 32'h1);
    rdchk(OFS_STATUS, 32'h0);
    acc(1'b1, OFS_WAKE, 32'h1);
    // Full speed idle, suspend granted by flag clear, clock stopped
    acc(1'b1, OFS_MASK, 32'h14);
    @(posedge clock);
    bus_idle <= 1'b1;
    n = 0;
    while (irq_seen !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    `CHK(n >= IDLE && n <= IDLE + 4, 1'b1)
    rdchk(OFS_STATUS, 32'h10);
    rdchk(OFS_STATE, 32'h4);
    acc(1'b1, OFS_STATUS, 32'h0);
    rdchk(OFS_STATUS, 32'h10);
    `CHK(suspended, 1'b0)
    acc(1'b1, OFS_CTRL, 32'h40);
    acc(1'b1, OFS_STATUS, 32'h10);
    rdchk(OFS_STATE, 32'h8);
    `CHK(core_clock_stop, 1'b1)
    flip(0);
    rdchk(OFS_STATUS, 32'h0);
    `CHK(irq_seen, 1'b0)
    @(posedge clock);
    bus_idle <= 1'b0;
    hop(4);
    `CHK(suspended, 1'b0)
    rdchk(OFS_STATUS, 32'h4);
    acc(1'b1, OFS_STATUS, 32'h4);
    acc(1'b1, OFS_WAKE, 32'h1);
    // High speed idle reverts first, then resume on wake event
    acc(1'b1, OFS_CTRL, 32'h20);
    @(posedge clock);
    high_speed <= 1'b1;
    bus_idle <= 1'b1;
    n = 0;
    while (revert_full_speed !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (revert_full_speed === 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    `CHK(n >= 1 && n <= REV, 1'b1)
    hop(3);
    rdchk(OFS_STATUS, 32'h10);
    acc(1'b1, OFS_STATUS, 32'h10);
    hop(1);
    `CHK(suspended, 1'b1)
    `CHK(core_clock_stop, 1'b0)
    flip(0);
    n = 0;
    while (resume_signal !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    `CHK(resume_signal, 1'b1)
    results();
  end
endmodule // usw_dev_test
